// File: design/lfs_pkg.sv
package lfs_pkg;
    // system clock rate
    localparam int unsigned SYS_CLK_HZ        = 250_000_000;
    // triangle dither pattern repetition rate (12.5 kHz), held in millihertz
    localparam int unsigned DITHER_RATE_MHZ   = 12_500_000;  // in millihertz
    // enable-low period that clears latched faults, in clock cycles
    localparam int unsigned SHUTDOWN_CYCLES   = 32_750;
    // dither band, percent each side of the programmed rate
    localparam int unsigned DITHER_BAND_PCT   = 5;
    // nominal switching period in system clocks and dither depth derived from it
    localparam int unsigned NOM_PERIOD        = 200;
    localparam int unsigned DITHER_SPAN       = NOM_PERIOD * DITHER_BAND_PCT / 100;
    // one triangle covers 4*span steps (up span, down span on each side of zero)
    localparam int unsigned DITHER_STEPS      = 4 * DITHER_SPAN;
    // system clocks between dither steps
    localparam int unsigned DITHER_STEP_CYC   =
        (SYS_CLK_HZ / (DITHER_RATE_MHZ / 1000)) / DITHER_STEPS;
    // maximum on-time share of the nominal switching period, the maximum duty
    localparam int unsigned MAX_DUTY_PCT      = 80;
    localparam int unsigned CNT_W             = 16;
    localparam int unsigned NUM_SINKS         = 4;
    // phase of the dither counter
    typedef enum logic {LFS_UP, LFS_DOWN} lfs_dir_type;
    // supervisor operating states
    typedef enum logic [1:0] {LFS_OFF, LFS_STARTUP, LFS_RUN, LFS_LATCHED} lfs_state_type;
endpackage : lfs_pkg

// File: design/lfs_supervisor.sv
`timescale 1ns/100ps
module lfs_supervisor (
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          dim_enable,
    input  wire logic                          uvlo_active,
    input  wire logic                          primary_switch_current_limit,
    input  wire logic                          secondary_switch_current_limit,
    input  wire logic                          input_sense_trip_level,
    input  wire logic                          switch_overvoltage_level,
    input  wire logic                          output_overvoltage_threshold,
    input  wire logic                          current_set_pin_fault,
    input  wire logic                          frequency_set_pin_fault,
    input  wire logic [lfs_pkg::NUM_SINKS-1:0] led_sink_pin_short,
    input  wire logic [lfs_pkg::NUM_SINKS-1:0] led_sink_pin_open,
    input  wire logic [lfs_pkg::NUM_SINKS-1:0] led_sink_in_reg,
    input  wire logic                          soft_start_done,
    output logic                               boost_gate,
    output logic                               disconnect_on,
    output logic [lfs_pkg::NUM_SINKS-1:0]      led_sink_enable,
    output logic                               fault_flag_n,
    output logic                               soft_start_run,
    output logic                               raise_vout,
    output logic                               low_power
);
    // overview: one clock, three groups of state. the dither counter walks the
    // period between its band edges; the fault group sorts detector inputs into
    // latched and auto-restart sets and sequences off, startup, run and latched;
    // the output group builds every pin but low_power from those and registers it.
    // limitation: the analog detectors are taken as already filtered and
    // synchronous, so a glitch on one of them is acted on at once
    // dither span and nominal period, as divider counts
    localparam logic [lfs_pkg::CNT_W-1:0] SPAN   = lfs_pkg::CNT_W'(lfs_pkg::DITHER_SPAN);
    localparam logic [lfs_pkg::CNT_W-1:0] NOM    = lfs_pkg::CNT_W'(lfs_pkg::NOM_PERIOD);

    // system clocks per dither step, less one for the terminal compare
    localparam logic [lfs_pkg::CNT_W-1:0] STEPC  = lfs_pkg::CNT_W'(lfs_pkg::DITHER_STEP_CYC - 1);

    // enable-low count at which the shutdown clear fires
    localparam logic [lfs_pkg::CNT_W-1:0] SHUTC  = lfs_pkg::CNT_W'(lfs_pkg::SHUTDOWN_CYCLES - 1);

    // on-time ceiling; keeps a minimum off-time so the switch always recovers
    localparam logic [lfs_pkg::CNT_W-1:0] ONMAX  =
        lfs_pkg::CNT_W'(lfs_pkg::NOM_PERIOD * lfs_pkg::MAX_DUTY_PCT / 100);

    // any condition that latches the device off
    function automatic logic latch_cause(input logic oc2, input logic vs, input logic swov);
        latch_cause = oc2 | vs | swov;
    endfunction : latch_cause

    // sequencing, dither and fault state
    lfs_pkg::lfs_state_type            state_q, state_d;
    lfs_pkg::lfs_dir_type              dir_q, dir_d;
    logic [lfs_pkg::CNT_W-1:0]         offs_q, offs_d;      // 0..2*span, centre at span
    logic [lfs_pkg::CNT_W-1:0]         step_q, step_d;
    logic [lfs_pkg::CNT_W-1:0]         per_q, per_d;        // position in switching period
    logic [lfs_pkg::CNT_W-1:0]         low_q, low_d;        // enable-low counter
    logic                              trunc_q, trunc_d;
    logic [2:0]                        latched_q, latched_d;
    logic [1:0]                        auto_q, auto_d;
    logic [lfs_pkg::NUM_SINKS-1:0]     drop_q, drop_d;
    logic                              ovp_seen_q, ovp_seen_d;

    // registered outputs, one flop each so no pin ever sees a decode glitch
    logic                              boost_q, boost_d;
    logic                              disc_q, disc_d;
    logic [lfs_pkg::NUM_SINKS-1:0]     sink_q, sink_d;
    logic                              flag_n_q, flag_n_d;
    logic                              ss_q, ss_d;
    logic                              raise_q, raise_d;
    logic                              lp_q, lp_d;

    // combinational helpers
    logic [lfs_pkg::CNT_W-1:0]         period_len;
    logic                              any_latch;

    // dithered period: offsets the nominal divider by -span..+span
    assign period_len = NOM - SPAN + offs_q;
    assign any_latch  = latch_cause(secondary_switch_current_limit,
                                    input_sense_trip_level, switch_overvoltage_level);

    // triangle dither counter, stepped so one sweep lasts one 12.5 kHz period
    // the offset starts at the centre, climbs to 2*span, falls to zero and
    // climbs back, so the period walks the whole band in single-count steps;
    // one count per step keeps the energy spread evenly, with no jumps
    always_comb begin
        dir_d  = dir_q;
        offs_d = offs_q;
        step_d = step_q + 16'h0001;
        if (step_q == STEPC) begin
            step_d = '0;
            if (dir_q == lfs_pkg::LFS_UP) begin
                offs_d = offs_q + 16'h0001;
                if (offs_q + 16'h0001 == 2 * SPAN)
                    dir_d = lfs_pkg::LFS_DOWN;
            end else begin
                offs_d = offs_q - 16'h0001;
                if (offs_q == 16'h0001)
                    dir_d = lfs_pkg::LFS_UP;
            end
        end
    end

    // dither registers; reset starts the sweep at the programmed frequency
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dir_q  <= lfs_pkg::LFS_UP;
            offs_q <= SPAN;
            step_q <= '0;
        end else begin
            dir_q  <= dir_d;
            offs_q <= offs_d;
            step_q <= step_d;
        end
    end

    // fault bookkeeping and state sequencing; latched and auto faults apart
    // the latched set only grows here except at the two clearing events,
    // shutdown and undervoltage, and even there a trip that is still present
    // is taken again, so a clear can never hide a live fault
    always_comb begin
        state_d    = state_q;
        low_d      = low_q;
        latched_d  = latched_q;
        auto_d     = {current_set_pin_fault, frequency_set_pin_fault};
        drop_d     = drop_q;
        ovp_seen_d = ovp_seen_q;
        lp_d       = 1'b0;

        // enable-low counter saturates one past the shutdown count
        // stopping one past the count keeps the clear from repeating in shutdown
        if (dim_enable)
            low_d = '0;
        else if (low_q != SHUTC + 16'h0001)
            low_d = low_q + 16'h0001;

        // secondary limit, input trip, switch overvoltage always watched
        // these three are live in every state, startup included
        if (secondary_switch_current_limit) latched_d[0] = 1'b1;
        if (input_sense_trip_level)         latched_d[1] = 1'b1;
        if (switch_overvoltage_level)       latched_d[2] = 1'b1;

        // open sinks: only judged in run, drop those out of regulation at ovp
        // masked in startup, where the output has not yet reached its level
        if (state_q == lfs_pkg::LFS_RUN && |(led_sink_pin_open & ~drop_q)) begin
            if (output_overvoltage_threshold) begin
                drop_d     = drop_q | ~led_sink_in_reg;
                ovp_seen_d = 1'b1;
            end
        end else if (!output_overvoltage_threshold) begin
            ovp_seen_d = 1'b0;
        end

        // sequencing: off waits for enable, startup for a clean soft-start
        unique case (state_q)
            lfs_pkg::LFS_OFF: begin
                lp_d = 1'b1;
                if (dim_enable) state_d = lfs_pkg::LFS_STARTUP;
            end
            lfs_pkg::LFS_STARTUP: begin
                if (soft_start_done && !(|led_sink_pin_short))
                    state_d = lfs_pkg::LFS_RUN;
            end
            lfs_pkg::LFS_RUN: ;
            lfs_pkg::LFS_LATCHED: ;
        endcase

        // any latched trip overrides the sequence until a clear; a frequency-set fault in run defers it one cycle
        if (any_latch || latched_q != 3'h0)
            state_d = lfs_pkg::LFS_LATCHED;

        // frequency-set fault forces a fresh soft-start
        if (frequency_set_pin_fault && state_q == lfs_pkg::LFS_RUN)
            state_d = lfs_pkg::LFS_STARTUP;

        // long enable low: shutdown clears latched faults (a new trip still sets)
        if (low_q == SHUTC) begin
            latched_d = {switch_overvoltage_level, input_sense_trip_level,
                         secondary_switch_current_limit};
            drop_d    = '0;
            state_d   = any_latch ? lfs_pkg::LFS_LATCHED : lfs_pkg::LFS_OFF;
        end

        // undervoltage lockout resets every latched fault; a trip still present
        // is taken again, like the shutdown clear
        if (uvlo_active) begin
            latched_d = {switch_overvoltage_level, input_sense_trip_level,
                         secondary_switch_current_limit};
            drop_d    = '0;
            state_d   = lfs_pkg::LFS_OFF;
            lp_d      = 1'b0;
        end
    end

    // fault and sequence registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q    <= lfs_pkg::LFS_OFF;
            low_q      <= '0;
            latched_q  <= '0;
            auto_q     <= '0;
            drop_q     <= '0;
            ovp_seen_q <= 1'b0;
            lp_q       <= 1'b0;
        end else begin
            state_q    <= state_d;
            low_q      <= low_d;
            latched_q  <= latched_d;
            auto_q     <= auto_d;
            drop_q     <= drop_d;
            ovp_seen_q <= ovp_seen_d;
            lp_q       <= lp_d;
        end
    end

    // switching period, on-time truncation and output gating
    // every output but low_power is decided here from the present state and live detectors,
    // then registered, so a detector edge reaches the pins one clock later
    always_comb begin
        logic run_ok;
        logic kill;
        run_ok   = 1'b0;
        kill     = 1'b0;
        per_d    = (per_q >= period_len - 16'h0001) ? '0 : per_q + 16'h0001;
        trunc_d  = trunc_q;
        // the wrap ends a truncation, so the next cycle always starts normally
        // and a stuck limit is still held off by the direct term in boost_d
        if (per_d == '0)
            trunc_d = 1'b0;
        else if (primary_switch_current_limit)
            trunc_d = 1'b1;
        // anything that must leave the whole stage dark
        kill     = any_latch || latched_q != 3'h0 || uvlo_active
                   || state_q == lfs_pkg::LFS_LATCHED || state_q == lfs_pkg::LFS_OFF;
        run_ok   = state_q == lfs_pkg::LFS_RUN && !kill;
        // startup sink short holds soft-start but leaves disconnect on
        ss_d     = state_q == lfs_pkg::LFS_STARTUP && !kill
                   && !(|led_sink_pin_short) && !frequency_set_pin_fault;
        disc_d   = !kill && !frequency_set_pin_fault;
        sink_d   = (run_ok && !current_set_pin_fault && !frequency_set_pin_fault)
                   ? ~drop_q : '0;
        // boost stops on output overvoltage, resumes once it falls
        boost_d  = (run_ok || ss_d) && !current_set_pin_fault
                   && !frequency_set_pin_fault && !output_overvoltage_threshold
                   && !primary_switch_current_limit && !trunc_d
                   && per_d < ONMAX;
        // open-pin search: ask for a higher output until the overvoltage answers
        raise_d  = run_ok && |(led_sink_pin_open & ~drop_q) && !ovp_seen_q;
        // flag low only for faults documented as flagging
        flag_n_d = !(latched_d != 3'h0 || frequency_set_pin_fault);
    end

    // output registers; reset leaves the stage dark with the flag released
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            per_q    <= '0;
            trunc_q  <= 1'b0;
            boost_q  <= 1'b0;
            disc_q   <= 1'b0;
            sink_q   <= '0;
            flag_n_q <= 1'b1;
            ss_q     <= 1'b0;
            raise_q  <= 1'b0;
        end else begin
            per_q    <= per_d;
            trunc_q  <= trunc_d;
            boost_q  <= boost_d;
            disc_q   <= disc_d;
            sink_q   <= sink_d;
            flag_n_q <= flag_n_d;
            ss_q     <= ss_d;
            raise_q  <= raise_d;
        end
    end

    // pins come straight from their flops
    assign boost_gate      = boost_q;
    assign disconnect_on   = disc_q;
    assign led_sink_enable = sink_q;
    assign fault_flag_n    = flag_n_q;
    assign soft_start_run  = ss_q;
    assign raise_vout      = raise_q;
    assign low_power       = lp_q;
endmodule : lfs_supervisor

// File: test/lfs_chk.sv
`timescale 1ns/100ps
module lfs_chk (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       dim_enable,
    input wire logic       uvlo_active,
    input wire logic       secondary_switch_current_limit,
    input wire logic       input_sense_trip_level,
    input wire logic       switch_overvoltage_level,
    input wire logic       output_overvoltage_threshold,
    input wire logic       current_set_pin_fault,
    input wire logic       frequency_set_pin_fault,
    input wire logic [3:0] led_sink_pin_short,
    input wire logic       boost_gate,
    input wire logic       disconnect_on,
    input wire logic [3:0] led_sink_enable,
    input wire logic       fault_flag_n,
    input wire logic       soft_start_run,
    input wire logic       low_power
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic        quiet, calm, dark;
    logic [15:0] low_q, low_d;
    // no undervoltage, frequency-set or latching trip present, and the whole output stage dark
    assign quiet = ~uvlo_active & ~frequency_set_pin_fault & ~secondary_switch_current_limit
                 & ~input_sense_trip_level & ~switch_overvoltage_level;
    assign calm = quiet & dim_enable;
    assign dark = ~disconnect_on & ~boost_gate & ~|led_sink_enable;
    // enable-low run length; saturates so a very long low never wraps back
    always_comb low_d = (dim_enable | sys_rst) ? 16'h0000 : low_q + {15'h0000, low_q != 16'hFFFF};
    always_ff @(posedge sys_clk) low_q <= low_d;
    sec_latch_a: assert property (secondary_switch_current_limit |=> dark && !fault_flag_n)
        else $error("secondary limit did not shut down");
    sense_latch_a: assert property (input_sense_trip_level |=> dark && !fault_flag_n)
        else $error("input sense trip did not shut down");
    node_latch_a: assert property (switch_overvoltage_level |=> dark && !fault_flag_n)
        else $error("switch node overvoltage did not shut down");
    latch_hold_a: assert property (secondary_switch_current_limit && dim_enable
        ##1 (dim_enable && !uvlo_active)[*8] |-> dark && !fault_flag_n)
        else $error("latched fault released while enable high");
    uvlo_off_a: assert property (uvlo_active |=> dark)
        else $error("undervoltage did not turn stage off");
    frequency_set_pin_off_a: assert property (frequency_set_pin_fault && !uvlo_active |=> dark && !fault_flag_n)
        else $error("frequency-set fault did not turn all off");
    current_set_pin_stop_a: assert property (current_set_pin_fault && disconnect_on && calm
        |=> !boost_gate && !(|led_sink_enable) && disconnect_on && fault_flag_n)
        else $error("current-set fault response wrong");
    ovp_stop_a: assert property (output_overvoltage_threshold && disconnect_on && calm
        |=> !boost_gate && disconnect_on && fault_flag_n)
        else $error("output overvoltage did not stop switching alone");
    short_hold_a: assert property ((|led_sink_pin_short) && disconnect_on && !soft_start_run && calm
        |=> !soft_start_run && !boost_gate && disconnect_on && fault_flag_n)
        else $error("shorted sink did not hold soft-start");
    shut_clear_a: assert property (32'(low_q) == lfs_pkg::SHUTDOWN_CYCLES && quiet
        |-> ##[0:2] low_power && fault_flag_n)
        else $error("long enable low did not shut down");
    cover property (!quiet ##1 !fault_flag_n);
    cover property ($rose(low_power));
    cover property ((|led_sink_pin_short) && disconnect_on);
endmodule : lfs_chk
bind lfs_supervisor lfs_chk u_chk (.*);

// File: test/lfs_stage_model.sv
`timescale 1ns/100ps
// far side: soft-start ramp, string regulation, switch current growing with on-time
module lfs_stage_model (
    input  wire logic       sys_clk,
    input  wire logic       soft_start_run,
    input  wire logic       boost_gate,
    input  wire logic [3:0] led_sink_enable,
    input  wire logic [3:0] led_sink_pin_open,
    input  wire logic [7:0] ramp_cycles,
    input  wire logic [7:0] limit_on,
    output logic            soft_start_done,
    output logic [3:0]      led_sink_in_reg,
    output logic            primary_switch_current_limit
);
    logic [7:0] ramp_q, ramp_d, on_q, on_d;
    // ramp restarts when soft-start is withdrawn, so quick and slow starts both occur
    always_comb begin
        ramp_d = soft_start_run ? ramp_q + {7'h00, ramp_q != 8'hFF} : 8'h00;
        on_d = boost_gate ? on_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge sys_clk) begin
        ramp_q <= ramp_d;
        on_q <= on_d;
    end
    // an open string never regulates; zero limit_on means no overload
    assign soft_start_done = ramp_q >= ramp_cycles;
    assign led_sink_in_reg = led_sink_enable & ~led_sink_pin_open;
    assign primary_switch_current_limit = (limit_on != 8'h00) && (on_q >= limit_on);
endmodule : lfs_stage_model

// File: test/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        sys_clk, sys_rst, dim_enable, uvlo_active, soft_start_done, raise_vout;
    logic        boost_gate, disconnect_on, fault_flag_n, soft_start_run, low_power;
    logic        primary_switch_current_limit;
    logic [5:0]  trips;  // secondary, sense, node, output ovp, current-set, frequency-set
    logic [3:0]  led_sink_pin_short, led_sink_pin_open, led_sink_in_reg, led_sink_enable, dropped;
    logic [7:0]  ramp_cycles, limit_on, seen;
    logic [15:0] note;
    logic [15:0] exp_q[$];
    int          fails = 0;
    int          comparisons = 0;
    wire         secondary_switch_current_limit = trips[0];
    wire         input_sense_trip_level = trips[1];
    wire         switch_overvoltage_level = trips[2];
    wire         output_overvoltage_threshold = trips[3];
    wire         current_set_pin_fault = trips[4];
    wire         frequency_set_pin_fault = trips[5];
    lfs_supervisor DUT (.*);
    lfs_stage_model u_stage (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // notes are {mask, value} of {disconnect, sinks, flag_n, soft-start, low power}
    // sampled mid-cycle, well clear of the edge that launches the outputs
    always @(negedge sys_clk) begin
        if (exp_q.size() != 0) begin
            note = exp_q.pop_front();
            seen = {disconnect_on, led_sink_enable, fault_flag_n, soft_start_run, low_power};
            comparisons++;
            if ((seen & note[15:8]) !== (note[7:0] & note[15:8])) begin
                fails++;
                $display("ERROR outputs expected %h seen %h mask %h", note[7:0], seen, note[15:8]);
            end
        end
    end
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic expect_out(input logic [7:0] mask, input logic [7:0] val);
        exp_q.push_back({mask, val});
        step(1);
    endtask : expect_out
    task automatic check(input string what, input bit ok, input int expv, input int got);
        comparisons++;
        if (!ok) begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", what, expv, got);
        end
    endtask : check
    // bounded wait on {raise_vout, sinks}; running out ends the run
    task automatic wait_out(input logic [4:0] mask, input logic [4:0] want);
        int i;
        for (i = 0; i < 4000 && (({raise_vout, led_sink_enable} & mask) !== want); i++) step(1);
        if (i == 4000) begin
            fails++;
            $display("ERROR wait expected %h seen %h", want, {raise_vout, led_sink_enable});
            final_report();
        end
    endtask : wait_out
    task automatic bring_up;
        dim_enable = 1'b1;
        ramp_cycles = 8'($urandom_range(60, 1));
        wait_out(5'h0F, 5'h0F);
    endtask : bring_up
    // switching period band and on-time cap seen over more than one sweep
    task automatic measure(input int n);
        int last, pmin, pmax, run, rmax, lo, hi, tlo, thi;
        {last, pmin, pmax, run, rmax} = {32'd0, 32'd999, 32'd0, 32'd0, 32'd0};
        lo = lfs_pkg::NOM_PERIOD - lfs_pkg::DITHER_SPAN;
        hi = lfs_pkg::NOM_PERIOD + lfs_pkg::DITHER_SPAN;
        tlo = -1;
        thi = -1;
        for (int t = 0; t < n; t++) begin
            step(1);
            run = (boost_gate === 1'b1) ? run + 1 : 0;
            rmax = (run > rmax) ? run : rmax;
            if (run == 1 && t > 1000) begin
                pmin = (t - last < pmin) ? t - last : pmin;
                pmax = (t - last > pmax) ? t - last : pmax;
                tlo = (t - last == lo && tlo < 0) ? t : tlo;
                thi = (t - last == hi && thi < 0) ? t : thi;
            end
            last = (run == 1) ? t : last;
        end
        check("shortest period", pmin == lo, lo, pmin);
        check("longest period", pmax == hi, hi, pmax);
        check("longest on-time", rmax <= int'(limit_on) + 2, int'(limit_on) + 2, rmax);
        check("half sweep", (tlo > thi ? tlo - thi : thi - tlo) inside {[9000:11000]}, 10000, tlo - thi);
    endtask : measure
    initial begin
        void'($urandom(32'hFC8BDCA4));
        {sys_rst, dim_enable, uvlo_active, trips, led_sink_pin_short, led_sink_pin_open} = 17'h10000;
        {ramp_cycles, limit_on} = 16'h0500;
        step(12);
        sys_rst = 1'b0;
        expect_out(8'hFF, 8'h04);
        led_sink_pin_short = 4'($urandom_range(15, 1));
        dim_enable = 1'b1;
        step(20);
        expect_out(8'hFF, 8'h84);
        led_sink_pin_short = 4'h0;
        bring_up();
        limit_on = 8'h14;
        measure(25000);
        expect_out(8'hFE, 8'hFC);
        limit_on = 8'h00;
        trips = 6'h08;
        step(3);
        expect_out(8'hFC, 8'hFC);
        trips = 6'h10;
        step(3);
        expect_out(8'hFC, 8'h84);
        trips = 6'h00;
        wait_out(5'h0F, 5'h0F);
        // open strings, answer the raise request with an output overvoltage
        led_sink_pin_open = 4'($urandom_range(14, 1));
        wait_out(5'h10, 5'h10);
        trips = 6'h08;
        step(4);
        trips = 6'h00;
        step(10);
        expect_out(8'hFC, {1'b1, ~led_sink_pin_open, 3'b100});
        dropped = led_sink_pin_open;
        led_sink_pin_open = 4'h0;
        trips = 6'h20;
        step(3);
        expect_out(8'hFC, 8'h00);
        trips = 6'h00;
        wait_out(5'h0F, {1'b0, ~dropped});
        // one-cycle latching trips; enable stays high and must not release them
        for (int k = 0; k < 3; k++) begin
            trips[k] = 1'b1;
            step(1);
            trips[k] = 1'b0;
            step(50);
            expect_out(8'hFC, 8'h00);
            if (k == 0) begin
                dim_enable = 1'b0;
                step(lfs_pkg::SHUTDOWN_CYCLES - 20);
                expect_out(8'hFC, 8'h00);
                step(40);
                expect_out(8'h05, 8'h05);
            end else begin
                uvlo_active = 1'b1;
                step(4);
                expect_out(8'hFC, 8'h04);
                uvlo_active = 1'b0;
            end
            bring_up();
        end
        step(2);
        final_report();
    end
endmodule : testbench
